// >>> src/smbus_pkg.sv
// Shared constants and types for the SMBus slave and its host controller
package smbus_pkg;
    localparam int          CLK_HZ        = 100_000_000;
    localparam logic [6:0]  DEV_ADDR      = 7'h2E;
    localparam logic [6:0]  ARA_ADDR      = 7'h0C;
    localparam logic [7:0]  REG_BASE      = 8'h40;
    localparam logic [2:0]  CFG_IDX       = 3'h0;
    localparam logic [2:0]  STAT_IDX      = 3'h1;
    localparam logic [2:0]  MASK_IDX      = 3'h2;
    localparam logic [2:0]  USER_IDX      = 3'h3;
    localparam int          REG_COUNT     = 8;
    localparam logic [7:0]  REG_RESET     = 8'h00;
    localparam int          TIMEOUT_OFF_BIT = 6;
    localparam int          LOCK_BIT      = 1;
    localparam int          TIMEOUT_MS    = 35;
    localparam int          TIMEOUT_CYC   = TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int          TIMEOUT_W     = 24;
    localparam int          SCL_HZ        = 100_000;
    localparam int          QUARTER_CYC   = CLK_HZ / (4 * SCL_HZ);
    localparam logic [7:0]  H_CTRL_OFS    = 8'h00;
    localparam logic [7:0]  H_CMD_OFS     = 8'h04;
    localparam logic [7:0]  H_DATA_OFS    = 8'h08;
    localparam logic [7:0]  H_STAT_OFS    = 8'h0C;
    localparam logic [7:0]  H_IRQ_OFS     = 8'h10;
    localparam logic [7:0]  H_MASK_OFS    = 8'h14;

    typedef enum logic [1:0] {
        OP_SEND  = 2'b00,
        OP_WRITE = 2'b01,
        OP_RECV  = 2'b10,
        OP_SEND_READ = 2'b11
    } op_t;

    typedef enum logic [1:0] {
        K_START = 2'b00,
        K_TX    = 2'b01,
        K_RX    = 2'b10,
        K_STOP  = 2'b11
    } step_kind_t;

    typedef enum logic [3:0] {
        S_IDLE     = 4'h0,
        S_ADDR     = 4'h1,
        S_ACK_ADDR = 4'h2,
        S_CMD      = 4'h3,
        S_ACK_CMD  = 4'h4,
        S_DATA     = 4'h5,
        S_ACK_DATA = 4'h6,
        S_TX       = 4'h7,
        S_RX_ACK   = 4'h8,
        S_SKIP     = 4'h9
    } dev_state_t;
endpackage

// >>> src/smbus_if.sv
// Open-drain SMBus wires joining the slave device and the host controller
`timescale 1ns/1ps
`default_nettype none
interface smbus_if;
    logic dev_sda_o;
    logic dev_sda_oe_n;
    logic dev_alert_o;
    logic dev_alert_oe_n;
    logic host_scl_o;
    logic host_scl_oe_n;
    logic host_sda_o;
    logic host_sda_oe_n;
    logic scl;
    logic sda;
    logic alert_n;

    // Pull-ups win wherever nobody drives low
    assign scl     = host_scl_oe_n | host_scl_o;
    assign sda     = (dev_sda_oe_n | dev_sda_o) & (host_sda_oe_n | host_sda_o);
    assign alert_n = dev_alert_oe_n | dev_alert_o;

    modport device (input scl, sda, alert_n,
                    output dev_sda_o, dev_sda_oe_n, dev_alert_o, dev_alert_oe_n);
    modport host   (input scl, sda, alert_n,
                    output host_scl_o, host_scl_oe_n, host_sda_o, host_sda_oe_n);
endinterface
`default_nettype wire

// >>> src/smbus_host.sv
// SMBus host controller driven from classic Wishbone registers
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module smbus_host (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq_o,
    smbus_if.host            bus
);
    typedef struct packed {
        logic       scl_oe_n;
        logic       sda_oe_n;
        logic [1:0] sda_s;
        logic [1:0] alert_s;
        logic       busy;
        logic       nack;
        logic [1:0] op;
        logic [6:0] addr;
        logic [7:0] cmd;
        logic [7:0] data;
        logic [7:0] rx;
        logic [7:0] sh;
        logic [7:0] qcnt;
        logic [1:0] ph;
        logic [3:0] bitn;
        logic [2:0] idx;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic       irq;
        logic       ack;
        logic [31:0] dat;
    } host_t;

    host_t q;
    host_t d;
    logic [3:0] cur;
    logic [3:0] nxt;
    logic       tick;
    logic       wr;

    // Step sequence per operation: {kind, byte select}
    function automatic logic [3:0] step_f(input logic [1:0] op, input logic [2:0] idx);
        logic [3:0] r;
        r = {smbus_pkg::K_STOP, 2'h0};
        unique case ({op, idx})
            {smbus_pkg::OP_SEND, 3'h1}, {smbus_pkg::OP_WRITE, 3'h1},
            {smbus_pkg::OP_SEND_READ, 3'h1}:  r = {smbus_pkg::K_TX, 2'h0};
            {smbus_pkg::OP_SEND, 3'h2}, {smbus_pkg::OP_WRITE, 3'h2},
            {smbus_pkg::OP_SEND_READ, 3'h2}:  r = {smbus_pkg::K_TX, 2'h2};
            {smbus_pkg::OP_WRITE, 3'h3}:      r = {smbus_pkg::K_TX, 2'h3};
            {smbus_pkg::OP_RECV, 3'h1},
            {smbus_pkg::OP_SEND_READ, 3'h4}:  r = {smbus_pkg::K_TX, 2'h1};
            {smbus_pkg::OP_RECV, 3'h2},
            {smbus_pkg::OP_SEND_READ, 3'h5}:  r = {smbus_pkg::K_RX, 2'h0};
            {smbus_pkg::OP_SEND, 3'h0}, {smbus_pkg::OP_WRITE, 3'h0},
            {smbus_pkg::OP_RECV, 3'h0}, {smbus_pkg::OP_SEND_READ, 3'h0},
            {smbus_pkg::OP_SEND_READ, 3'h3}:  r = {smbus_pkg::K_START, 2'h0};
            default:                          r = {smbus_pkg::K_STOP, 2'h0};
        endcase
        return r;
    endfunction

    function automatic logic [7:0] byte_f(input logic [1:0] sel, input host_t s);
        unique case (sel)
            2'h0: return {s.addr, 1'b0};
            2'h1: return {s.addr, 1'b1};
            2'h2: return s.cmd;
            2'h3: return s.data;
        endcase
    endfunction

    always_comb begin
        d = q;
        d.sda_s = {q.sda_s[0], bus.sda};
        d.alert_s = {q.alert_s[0], bus.alert_n};
        cur = step_f(q.op, q.idx);
        nxt = step_f(q.op, q.idx + 3'h1);
        tick = q.busy && (q.qcnt == 8'(smbus_pkg::QUARTER_CYC - 1));
        wr = wb_cyc_i && wb_stb_i && wb_we_i && !q.ack;
        d.ack = wb_cyc_i && wb_stb_i && !q.ack;
        d.qcnt = (!q.busy || tick) ? 8'h00 : q.qcnt + 8'h01;
        // Register writes; a start request while busy is dropped
        if (wr && wb_adr_i == smbus_pkg::H_CTRL_OFS && wb_sel_i[0] && !q.busy) begin
            d.op = wb_dat_i[1:0];
            d.busy = 1'b1;
            d.nack = 1'b0;
            d.idx = 3'h0;
            d.ph = 2'h0;
            d.bitn = 4'h0;
            if (wb_sel_i[1]) begin
                d.addr = wb_dat_i[14:8];
            end
        end
        if (wr && wb_adr_i == smbus_pkg::H_CMD_OFS && wb_sel_i[0] && !q.busy) begin
            d.cmd = wb_dat_i[7:0];
        end
        if (wr && wb_adr_i == smbus_pkg::H_DATA_OFS && wb_sel_i[0] && !q.busy) begin
            d.data = wb_dat_i[7:0];
        end
        if (wr && wb_adr_i == smbus_pkg::H_IRQ_OFS && wb_sel_i[0]) begin
            d.irq_stat = q.irq_stat & ~wb_dat_i[2:0];
        end
        if (wr && wb_adr_i == smbus_pkg::H_MASK_OFS && wb_sel_i[0]) begin
            d.irq_mask = wb_dat_i[2:0];
        end
        // Bit engine, four quarters per SCL period
        if (tick) begin
            d.ph = q.ph + 2'h1;
            unique case (smbus_pkg::step_kind_t'(cur[3:2]))
                smbus_pkg::K_START: begin
                    unique case (q.ph)
                        2'h0: begin d.scl_oe_n = 1'b0; d.sda_oe_n = 1'b1; end
                        2'h1: d.scl_oe_n = 1'b1;
                        2'h2: d.sda_oe_n = 1'b0;
                        2'h3: d.scl_oe_n = 1'b0;
                    endcase
                end
                smbus_pkg::K_STOP: begin
                    unique case (q.ph)
                        2'h0: begin d.scl_oe_n = 1'b0; d.sda_oe_n = 1'b0; end
                        2'h1: d.scl_oe_n = 1'b1;
                        2'h2: d.sda_oe_n = 1'b1;
                        2'h3: begin
                            d.busy = 1'b0;
                            d.irq_stat[0] = 1'b1;
                            // A clear landing with the stop must not be undone
                            d.irq_stat[1] = d.irq_stat[1] | q.nack;
                        end
                    endcase
                end
                smbus_pkg::K_TX, smbus_pkg::K_RX: begin
                    unique case (q.ph)
                        2'h0: begin
                            d.scl_oe_n = 1'b0;
                            d.sda_oe_n = (cur[3:2] == smbus_pkg::K_TX && q.bitn != 4'h8) ?
                                         q.sh[7] : 1'b1;
                        end
                        2'h1: d.scl_oe_n = 1'b1;
                        2'h2: begin
                            if (cur[3:2] == smbus_pkg::K_RX && q.bitn != 4'h8) begin
                                d.sh = {q.sh[6:0], q.sda_s[1]};
                            end
                            if (cur[3:2] == smbus_pkg::K_TX && q.bitn == 4'h8) begin
                                d.nack = q.sda_s[1];
                            end
                        end
                        2'h3: begin
                            d.scl_oe_n = 1'b0;
                            d.bitn = q.bitn + 4'h1;
                            if (cur[3:2] == smbus_pkg::K_TX && q.bitn != 4'h8) begin
                                d.sh = {q.sh[6:0], 1'b0};
                            end
                        end
                    endcase
                end
            endcase
            // Step advance; a refused byte jumps straight to the stop
            if (q.ph == 2'h3 && (cur[3:2] == smbus_pkg::K_START || q.bitn == 4'h8)) begin
                d.bitn = 4'h0;
                d.idx = q.idx + 3'h1;
                d.sh = byte_f(nxt[1:0], q);
                if (cur[3:2] == smbus_pkg::K_RX) begin
                    d.rx = q.sh;
                end
                if (cur[3:2] == smbus_pkg::K_TX && d.nack) begin
                    d.idx = 3'h7;
                end
            end
        end
        if (!q.alert_s[1]) begin
            d.irq_stat[2] = 1'b1;
        end
        d.irq = |(d.irq_stat & d.irq_mask);
        unique case (wb_adr_i)
            smbus_pkg::H_CTRL_OFS: d.dat = {17'h0, q.addr, 6'h0, q.op};
            smbus_pkg::H_CMD_OFS:  d.dat = {24'h0, q.cmd};
            smbus_pkg::H_DATA_OFS: d.dat = {24'h0, q.data};
            smbus_pkg::H_STAT_OFS: d.dat = {16'h0, q.rx, 5'h0, ~q.alert_s[1], q.nack, q.busy};
            smbus_pkg::H_IRQ_OFS:  d.dat = {29'h0, q.irq_stat};
            smbus_pkg::H_MASK_OFS: d.dat = {29'h0, q.irq_mask};
            default:               d.dat = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.scl_oe_n <= 1'b1;
            q.sda_oe_n <= 1'b1;
            q.sda_s <= 2'h3;
            q.alert_s <= 2'h3;
        end else begin
            q <= d;
        end
    end

    assign wb_dat_o          = q.dat;
    assign wb_ack_o          = q.ack;
    assign irq_o             = q.irq;
    assign bus.host_scl_o    = 1'b0;
    assign bus.host_scl_oe_n = q.scl_oe_n;
    assign bus.host_sda_o    = 1'b0;
    assign bus.host_sda_oe_n = q.sda_oe_n;
endmodule
`default_nettype wire

// >>> src/smbus_device.sv
// SMBus slave register front end with alert, bus timeout and write lock
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Send byte: ack address, command, load pointer
// - Repeated start after pointer write starts read
// - Write byte: pointer then data into register
// - Receive byte: ack, send byte, master nacks
// - Read returns register selected by pointer
// - Answer alert address only while alerting
// - Yield on SDA when losing alert arbitration
// - Alert stays while condition persists
// - Alert is open-drain active-low
// - Idle bus 35 ms aborts transaction
// - Config bit 6 disables the timeout
// - Config bit 1 locks critical registers
// - Respond to address 0x2E, and to 0x0C only while alerting
// - First written byte always sets pointer
// - Writes carry two bytes, reads one
module smbus_device #(
    parameter int TIMEOUT_CYCLES = smbus_pkg::TIMEOUT_CYC
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [7:0] event_i,
    output logic      [7:0] cfg_o,
    output logic      [7:0] user_o,
    smbus_if.device         bus
);
    typedef struct packed {
        logic [2:0]                       scl_s;
        logic [2:0]                       sda_s;
        smbus_pkg::dev_state_t            st;
        logic [3:0]                       cnt;
        logic [7:0]                       sh;
        logic                             rw;
        logic [7:0]                       ptr;
        logic [smbus_pkg::REG_COUNT-1:0][7:0] regs;
        logic                             sda_oe_n;
        logic                             alert_oe_n;
        logic [smbus_pkg::TIMEOUT_W-1:0]  idle_cnt;
    } dev_t;

    dev_t q;
    dev_t d;
    logic scl_rise;
    logic scl_fall;
    logic sda_in;
    logic start_c;
    logic stop_c;
    logic edge_c;
    logic locked;

    // Register window: only the eight words above the base exist
    function automatic logic hit_f(input logic [7:0] ptr);
        return ptr[7:3] == smbus_pkg::REG_BASE[7:3];
    endfunction

    function automatic logic [7:0] read_f(input dev_t s);
        return hit_f(s.ptr) ? s.regs[s.ptr[2:0]] : 8'h00;
    endfunction

    always_comb begin
        d = q;
        // Second stage feeds logic, third stage is its previous value
        d.scl_s = {q.scl_s[1:0], bus.scl};
        d.sda_s = {q.sda_s[1:0], bus.sda};
        scl_rise = q.scl_s[1] & ~q.scl_s[2];
        scl_fall = ~q.scl_s[1] & q.scl_s[2];
        sda_in = q.sda_s[1];
        start_c = q.scl_s[1] & q.scl_s[2] & q.sda_s[2] & ~q.sda_s[1];
        stop_c = q.scl_s[1] & q.scl_s[2] & ~q.sda_s[2] & q.sda_s[1];
        edge_c = (q.scl_s[1] ^ q.scl_s[2]) | (q.sda_s[1] ^ q.sda_s[2]);
        locked = q.regs[smbus_pkg::CFG_IDX][smbus_pkg::LOCK_BIT];
        // Shift in on SCL rise for the three receiving states
        if (scl_rise && q.cnt != 4'h8 &&
            (q.st == smbus_pkg::S_ADDR || q.st == smbus_pkg::S_CMD ||
             q.st == smbus_pkg::S_DATA)) begin
            d.sh = {q.sh[6:0], sda_in};
            d.cnt = q.cnt + 4'h1;
        end
        if (start_c) begin
            // A start in any state, repeated or not, opens a new address phase
            d.st = smbus_pkg::S_ADDR;
            d.cnt = 4'h0;
            d.sda_oe_n = 1'b1;
        end else if (stop_c) begin
            d.st = smbus_pkg::S_IDLE;
            d.sda_oe_n = 1'b1;
        end else begin
            unique case (q.st)
                smbus_pkg::S_IDLE, smbus_pkg::S_SKIP: begin
                end
                smbus_pkg::S_ADDR: begin
                    if (scl_fall && q.cnt == 4'h8) begin
                        d.rw = q.sh[0];
                        d.cnt = 4'h0;
                        if (q.sh[7:1] == smbus_pkg::DEV_ADDR) begin
                            d.st = smbus_pkg::S_ACK_ADDR;
                            d.sda_oe_n = 1'b0;
                            d.sh = read_f(q);
                        end else if (q.sh[7:1] == smbus_pkg::ARA_ADDR && q.sh[0] &&
                                     !q.alert_oe_n) begin
                            d.st = smbus_pkg::S_ACK_ADDR;
                            d.sda_oe_n = 1'b0;
                            d.sh = {smbus_pkg::DEV_ADDR, 1'b0};
                        end else begin
                            d.st = smbus_pkg::S_SKIP;
                        end
                    end
                end
                smbus_pkg::S_ACK_ADDR: begin
                    if (scl_fall) begin
                        d.cnt = 4'h0;
                        if (q.rw) begin
                            d.st = smbus_pkg::S_TX;
                            d.sda_oe_n = q.sh[7];
                        end else begin
                            d.st = smbus_pkg::S_CMD;
                            d.sda_oe_n = 1'b1;
                        end
                    end
                end
                smbus_pkg::S_CMD: begin
                    if (scl_fall && q.cnt == 4'h8) begin
                        d.ptr = q.sh;
                        d.st = smbus_pkg::S_ACK_CMD;
                        d.sda_oe_n = 1'b0;
                    end
                end
                smbus_pkg::S_ACK_CMD: begin
                    if (scl_fall) begin
                        d.st = smbus_pkg::S_DATA;
                        d.cnt = 4'h0;
                        d.sda_oe_n = 1'b1;
                    end
                end
                smbus_pkg::S_DATA: begin
                    if (scl_fall && q.cnt == 4'h8) begin
                        // Always acked; a locked register simply keeps its value
                        d.st = smbus_pkg::S_ACK_DATA;
                        d.sda_oe_n = 1'b0;
                        if (hit_f(q.ptr)) begin
                            if (q.ptr[2:0] == smbus_pkg::STAT_IDX) begin
                                d.regs[smbus_pkg::STAT_IDX] =
                                    q.regs[smbus_pkg::STAT_IDX] & ~q.sh;
                            end else if (!locked) begin
                                d.regs[q.ptr[2:0]] = q.sh;
                            end
                        end
                    end
                end
                smbus_pkg::S_ACK_DATA: begin
                    if (scl_fall) begin
                        // Third and later bytes fall on a released line
                        d.st = smbus_pkg::S_SKIP;
                        d.sda_oe_n = 1'b1;
                    end
                end
                smbus_pkg::S_TX: begin
                    if (scl_rise) begin
                        if (q.sh[7] && !sda_in) begin
                            d.st = smbus_pkg::S_SKIP;
                            d.sda_oe_n = 1'b1;
                        end else begin
                            d.sh = {q.sh[6:0], 1'b0};
                            d.cnt = q.cnt + 4'h1;
                        end
                    end else if (scl_fall) begin
                        if (q.cnt == 4'h8) begin
                            d.st = smbus_pkg::S_RX_ACK;
                            d.sda_oe_n = 1'b1;
                        end else begin
                            d.sda_oe_n = q.sh[7];
                        end
                    end
                end
                smbus_pkg::S_RX_ACK: begin
                    if (scl_rise) begin
                        d.st = smbus_pkg::S_SKIP;
                    end
                end
                default: begin
                    d.st = smbus_pkg::S_IDLE;
                    d.sda_oe_n = 1'b1;
                end
            endcase
        end
        // Bus watchdog; counting only mid-transaction keeps an idle bus quiet
        if (q.st == smbus_pkg::S_IDLE || edge_c) begin
            d.idle_cnt = '0;
        end else if (q.idle_cnt != TIMEOUT_CYCLES[smbus_pkg::TIMEOUT_W-1:0]) begin
            d.idle_cnt = q.idle_cnt + 1'b1;
        end
        if (q.idle_cnt == TIMEOUT_CYCLES[smbus_pkg::TIMEOUT_W-1:0] &&
            !q.regs[smbus_pkg::CFG_IDX][smbus_pkg::TIMEOUT_OFF_BIT]) begin
            d.st = smbus_pkg::S_IDLE;
            d.sda_oe_n = 1'b1;
            d.idle_cnt = '0;
        end
        // Conditions still present re-set their bits after a clear
        d.regs[smbus_pkg::STAT_IDX] = d.regs[smbus_pkg::STAT_IDX] | event_i;
        d.alert_oe_n = ~|(d.regs[smbus_pkg::STAT_IDX] & d.regs[smbus_pkg::MASK_IDX]);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // Only this reset can drop the lock bit
            q <= '0;
            q.regs <= {smbus_pkg::REG_COUNT{smbus_pkg::REG_RESET}};
            q.scl_s <= 3'h7;
            q.sda_s <= 3'h7;
            q.sda_oe_n <= 1'b1;
            q.alert_oe_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign cfg_o              = q.regs[smbus_pkg::CFG_IDX];
    assign user_o             = q.regs[smbus_pkg::USER_IDX];
    assign bus.dev_sda_o      = 1'b0;
    assign bus.dev_sda_oe_n   = q.sda_oe_n;
    assign bus.dev_alert_o    = 1'b0;
    assign bus.dev_alert_oe_n = q.alert_oe_n;
endmodule
`default_nettype wire

// >>> dv/smbus_slave_register_access_asserts.sv
// Concurrent checks on the open-drain SMBus wires between host and slave
`timescale 1ns/1ps
`default_nettype none
module smbus_slave_register_access_asserts #(
    parameter int TIMEOUT_CYCLES = 2000
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic scl,
    input wire logic sda,
    input wire logic alert_n,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe_n,
    input wire logic dev_alert_o,
    input wire logic dev_alert_oe_n
);
    logic        scl_q;
    logic        sda_q;
    logic [31:0] hold_q;

    // Cycles the slave keeps SDA low with no wire edge at all
    always_ff @(posedge clk_i) begin
        scl_q <= scl;
        sda_q <= sda;
        if (rst_i || dev_sda_oe_n || scl != scl_q || sda != sda_q) begin
            hold_q <= 32'h0;
        end else begin
            hold_q <= hold_q + 32'h1;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence start_s;
        scl && $past(scl) && $fell(sda);
    endsequence
    sequence stop_s;
        scl && $past(scl) && $rose(sda);
    endsequence
    // Slave only moves SDA during the low phase that follows a clock fall
    sequence after_fall_s;
        !scl && ($past(scl, 3) || $past(scl, 4) || $past(scl, 5) || $past(scl, 6));
    endsequence

    AST_OD_VALUES: assert property (!dev_sda_o && !dev_alert_o)
        else $error("open-drain data value not zero");
    AST_ALERT_WIRED: assert property (!dev_alert_oe_n |-> !alert_n)
        else $error("alert enabled but line high");
    AST_RESET_RELEASE: assert property (disable iff (1'b0) rst_i |=> dev_sda_oe_n && dev_alert_oe_n)
        else $error("pins driven after reset");
    AST_START_RELEASED: assert property (start_s |-> dev_sda_oe_n)
        else $error("slave holds data at start");
    AST_STOP_IDLE: assert property (stop_s |=> dev_sda_oe_n [*8])
        else $error("slave drives data after stop");
    AST_DRIVE_AFTER_FALL: assert property ($changed(dev_sda_oe_n) |-> after_fall_s)
        else $error("slave data moved outside clock low");
    AST_HELD_WHILE_HIGH: assert property ($rose(scl) && !dev_sda_oe_n
        |-> !dev_sda_oe_n throughout (scl ##[0:600] !scl))
        else $error("slave released data while clock high");
    AST_TIMEOUT_BOUND: assert property (hold_q < 32'(TIMEOUT_CYCLES) + 32'h10)
        else $error("stuck bus not released in time");
endmodule
`default_nettype wire

// >>> dv/smbus_slave_register_access_tb.sv
// Testbench for the SMBus host and slave joined over open-drain wires
`timescale 1ns/1ps
`default_nettype none
module smbus_slave_register_access_tb;
    localparam int TMO = 2000;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc   = 1'b0;
    logic        stb   = 1'b0;
    logic        we    = 1'b0;
    logic [7:0]  adr   = 8'h00;
    logic [31:0] wdat  = 32'h0;
    logic [3:0]  sel   = 4'h0;
    logic [7:0]  ev    = 8'h00;
    logic [31:0] rdat;
    logic        ack;
    logic        irq;
    logic [7:0]  cfg;
    logic [7:0]  usr;
    int          n_fail = 0;
    int          num_checks = 0;

    smbus_if link ();
    smbus_host u_smbus_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat),
        .wb_ack_o(ack), .irq_o(irq), .bus(link));
    // Short timeout keeps a stuck bus visible within the run
    smbus_device #(.TIMEOUT_CYCLES(TMO)) u_smbus_device (.clk_i(clk_i), .rst_i(rst_i),
        .event_i(ev), .cfg_o(cfg), .user_o(usr), .bus(link));
    smbus_slave_register_access_asserts #(.TIMEOUT_CYCLES(TMO)) u_asserts (.clk_i(clk_i),
        .rst_i(rst_i), .scl(link.scl), .sda(link.sda), .alert_n(link.alert_n),
        .dev_sda_o(link.dev_sda_o), .dev_sda_oe_n(link.dev_sda_oe_n),
        .dev_alert_o(link.dev_alert_o), .dev_alert_oe_n(link.dev_alert_oe_n));

    always #5 clk_i = ~clk_i;

    task automatic summarize();
        if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        sel  <= 4'hF;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) begin
            n_fail++;
            summarize();
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic xfer(input logic [1:0] op, input logic [6:0] a, input logic [7:0] c,
                        input logic [7:0] d, output logic [31:0] st);
        int n;
        logic [31:0] q;
        wb(1'b1, smbus_pkg::H_CMD_OFS, {24'h0, c}, q);
        wb(1'b1, smbus_pkg::H_DATA_OFS, {24'h0, d}, q);
        wb(1'b1, smbus_pkg::H_CTRL_OFS, {17'h0, a, 6'h0, op}, q);
        n = 0;
        do begin
            wb(1'b0, smbus_pkg::H_STAT_OFS, 32'h0, st);
            n++;
        end while (st[0] !== 1'b0 && n < 30000);
        if (st[0] !== 1'b0) begin
            n_fail++;
            summarize();
        end
    endtask

    task automatic sc_reset_values();
        logic [31:0] q;
        check8("cfg", 8'h00, cfg);
        check8("user", 8'h00, usr);
        wb(1'b0, 8'h1C, 32'h0, q);
        check8("unmapped", 8'h00, q[7:0]);
        check8("alert_idle", 8'h01, {7'h0, link.alert_n});
    endtask

    task automatic sc_write_byte();
        logic [31:0] st;
        logic [31:0] q;
        wb(1'b1, smbus_pkg::H_MASK_OFS, 32'h0, q);
        xfer(smbus_pkg::OP_WRITE, smbus_pkg::DEV_ADDR, 8'h43, 8'hA5, st);
        check8("write_nack", 8'h00, {7'h0, st[1]});
        check8("user_reg", 8'hA5, usr);
        check8("irq_masked", 8'h00, {7'h0, irq});
        wb(1'b1, smbus_pkg::H_MASK_OFS, 32'h1, q);
        wb(1'b0, smbus_pkg::H_STAT_OFS, 32'h0, q);
        check8("irq_raised", 8'h01, {7'h0, irq});
        wb(1'b1, smbus_pkg::H_IRQ_OFS, 32'h7, q);
        wb(1'b0, smbus_pkg::H_STAT_OFS, 32'h0, q);
        check8("irq_cleared", 8'h00, {7'h0, irq});
    endtask

    // A foreign address must neither be acked nor move the pointer
    task automatic sc_bad_addr();
        logic [31:0] st;
        xfer(smbus_pkg::OP_SEND, smbus_pkg::DEV_ADDR ^ 7'h01, 8'h40, 8'h00, st);
        check8("foreign_nack", 8'h01, {7'h0, st[1]});
    endtask

    task automatic sc_receive();
        logic [31:0] st;
        xfer(smbus_pkg::OP_RECV, smbus_pkg::DEV_ADDR, 8'h00, 8'h00, st);
        check8("recv_nack", 8'h00, {7'h0, st[1]});
        check8("recv_data", 8'hA5, st[15:8]);
    endtask

    task automatic sc_alert();
        logic [31:0] st;
        xfer(smbus_pkg::OP_WRITE, smbus_pkg::DEV_ADDR, 8'h42, 8'h01, st);
        ev <= 8'h01;
        xfer(smbus_pkg::OP_RECV, smbus_pkg::ARA_ADDR, 8'h00, 8'h00, st);
        check8("ara_nack", 8'h00, {7'h0, st[1]});
        check8("ara_data", {smbus_pkg::DEV_ADDR, 1'b0}, st[15:8]);
        ev <= 8'h00;
        wb(1'b0, smbus_pkg::H_STAT_OFS, 32'h0, st);
        check8("alert_held", 8'h01, {7'h0, st[2]});
        check8("alert_pin", 8'h00, {7'h0, link.alert_n});
    endtask

    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        sc_reset_values();
        sc_write_byte();
        sc_bad_addr();
        sc_receive();
        sc_alert();
        summarize();
    end
endmodule
`default_nettype wire
